// ==== common/stdb_pkg.sv ====
// package with register map, field positions and reset values of the status bank
package stdb_pkg;
  // register addresses (7-bit)
  localparam logic [6:0] STDB_ADDR_SUPPLY = 7'h41;
  localparam logic [6:0] STDB_ADDR_THERMAL = 7'h42;
  localparam logic [6:0] STDB_ADDR_DEVINFO = 7'h43;
  // supply register field positions
  localparam int STDB_SUP_POR = 7;
  localparam int STDB_SUP_LIN_LOW = 6;
  localparam int STDB_SUP_MAIN_HIGH = 5;
  localparam int STDB_SUP_SEC_HOT = 4;
  localparam int STDB_SUP_SEC_LOW = 3;
  localparam int STDB_SUP_MAIN_SHORT = 2;
  localparam int STDB_SUP_RSVD = 1;
  localparam int STDB_SUP_MAIN_LOW = 0;
  // thermal register field positions
  localparam int STDB_TH_SEVERE = 2;
  localparam int STDB_TH_FIRST = 1;
  localparam int STDB_TH_PREWARN = 0;
  // device info field positions
  localparam int STDB_DI_PREV_HI = 7;
  localparam int STDB_DI_PREV_LO = 6;
  localparam int STDB_DI_RST_HIGH = 5;
  localparam int STDB_DI_FSI = 4;
  localparam int STDB_DI_WDC_HI = 3;
  localparam int STDB_DI_WDC_LO = 2;
  localparam int STDB_DI_SPI = 1;
  localparam int STDB_DI_FO = 0;
  // read-clear masks and reset values
  localparam logic [7:0] STDB_SUP_RC_MASK = 8'hFD;
  localparam logic [7:0] STDB_TH_MASK = 8'h07;
  localparam logic [7:0] STDB_DI_RC_MASK = 8'hF3;
  localparam logic [7:0] STDB_RESET_VAL = 8'h00;
  // previous-state encodings
  localparam logic [1:0] STDB_PREV_CLEAR = 2'h0;
  localparam logic [1:0] STDB_PREV_FAIL = 2'h1;
  localparam logic [1:0] STDB_PREV_SLEEP = 2'h2;
  // watchdog failure counter values
  localparam logic [1:0] STDB_WDC_NONE = 2'h0;
  localparam logic [1:0] STDB_WDC_ONE = 2'h1;
  localparam logic [1:0] STDB_WDC_TWO = 2'h2;
endpackage : stdb_pkg

// ==== rtl/stdb_flag_bit.sv ====
`timescale 1ns/1ps
// one sticky read-clear flag where a new event wins over a clear
module stdb_flag_bit (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic set_evt,
  input wire logic clr_req,
  // state
  output logic flag
);
  logic flag_reg; // stored flag
  logic flag_next; // next value

  // set has priority so that an event in the clearing cycle survives
  always_comb begin
    flag_next = flag_reg;
    if (set_evt) begin
      flag_next = 1'b1;
    end else if (clr_req) begin
      flag_next = 1'b0;
    end
  end

  // register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule : stdb_flag_bit

// ==== rtl/stdb_status_bank.sv ====
`timescale 1ns/1ps
// supply, thermal and device information status bank behind the 16-bit frame port
// Operation
// - one 16-bit frame: address, mode, ignored data
// - mode 0 reads, mode 1 reads and clears
// - flags change only by event or clear
// - supply flags at 0x41, seven read-clear
// - reset zeroes bits 7..0, por_event sets power flag
// - short event sets supply bit 2
// - supply bit 1 always reads zero
// - main off blocks short and low flags
// - second off blocks its low, hot flags
// - no active LIN blocks LIN low flag
// - thermal flags at 0x42, bits 2..0
// - severe shutdown sets flag, enters fail-safe
// - restart keeps thermal flags, upper bits read zero
// - info at 0x43, reset zero, kept through restart
// - previous state field codes before restart
// - failure causes give previous state 01
// - reset clamped high sets bit 5
// - fail-safe input pattern failure sets bit 4
// - watchdog counter counts one then two
// - counter stops at two, cleared by trigger
// - invalid command clear not executed, sets bit 1
// - invalid flag cleared only by command
// - fail outputs active sets bit 0
module stdb_status_bank
  import stdb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // frame port from the serial shifter, same clock
  input wire logic frame_valid,
  input wire logic [15:0] frame_data,
  input wire logic frame_invalid,
  output logic [7:0] read_data,
  output logic read_valid,
  // supply detectors, level per cycle
  input wire logic por_event,
  input wire logic lin_low_det,
  input wire logic main_high_det,
  input wire logic sec_hot_det,
  input wire logic sec_low_det,
  input wire logic main_short_det,
  input wire logic main_low_det,
  // regulator and transceiver state
  input wire logic main_on,
  input wire logic sec_on,
  input wire logic lin_active,
  // thermal detectors
  input wire logic severe_det,
  input wire logic first_det,
  input wire logic prewarn_det,
  // restart controller and fail-safe
  input wire logic restart_pulse,
  input wire logic restart_from_fail,
  input wire logic restart_from_sleep,
  input wire logic overvoltage_reset_enable,
  input wire logic watchdog_fail_evt,
  input wire logic watchdog_good_evt,
  input wire logic reset_stuck_det,
  input wire logic failsafe_input_pattern_flag_det,
  input wire logic fail_outputs_on,
  output logic failsafe_req,
  output logic [1:0] fail_safe_outputs
);
  logic rst_meta_reg; // first reset sync stage
  logic rst_sync_reg; // released reset copy
  logic rst_n; // internal reset

  // reset release through two flops, assert is asynchronous
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // frame decode: bits 6:0 address, bit 7 mode, data byte ignored
  logic [6:0] frame_addr;
  logic frame_clear;
  logic acc_ok;
  assign frame_addr = frame_data[6:0];
  assign frame_clear = frame_data[7];
  // an invalid command still returns its read byte, but its clear is never executed
  assign acc_ok = frame_valid && !frame_invalid;

  logic clr_sup; // clear request for supply flags
  logic clr_th; // clear request for thermal flags
  logic clr_di; // clear request for info flags
  assign clr_sup = acc_ok && frame_clear && (frame_addr == STDB_ADDR_SUPPLY);
  assign clr_th = acc_ok && frame_clear && (frame_addr == STDB_ADDR_THERMAL);
  assign clr_di = acc_ok && frame_clear && (frame_addr == STDB_ADDR_DEVINFO);

  // gated set events; a disabled supply cannot raise its flags, except main high, which is never gated
  logic [7:0] sup_set;
  always_comb begin
    sup_set = 8'h00;
    sup_set[STDB_SUP_POR] = por_event;
    sup_set[STDB_SUP_LIN_LOW] = lin_low_det && lin_active;
    sup_set[STDB_SUP_MAIN_HIGH] = main_high_det;
    sup_set[STDB_SUP_SEC_HOT] = sec_hot_det && sec_on;
    sup_set[STDB_SUP_SEC_LOW] = sec_low_det && sec_on;
    sup_set[STDB_SUP_MAIN_SHORT] = main_short_det && main_on;
    sup_set[STDB_SUP_MAIN_LOW] = main_low_det && main_on;
  end

  // sticky read-clear flags, one instance per bit; bit 1 stays reserved
  logic [7:0] sup_flags;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sup
      if (STDB_SUP_RC_MASK[gi]) begin : g_rc
        stdb_flag_bit u_bit (
          .clk(sys_clk),
          .rst_n(rst_n),
          .set_evt(sup_set[gi]),
          .clr_req(clr_sup),
          .flag(sup_flags[gi])
        );
      end else begin : g_rsvd
        assign sup_flags[gi] = 1'b0;
      end
    end
  endgenerate

  // thermal flags; restart leaves them untouched since only clear affects them
  logic [2:0] th_set;
  logic [2:0] th_flags;
  assign th_set = {severe_det, first_det, prewarn_det};
  generate
    for (gi = 0; gi < 3; gi++) begin : g_th
      stdb_flag_bit u_bit (
        .clk(sys_clk),
        .rst_n(rst_n),
        .set_evt(th_set[gi]),
        .clr_req(clr_th),
        .flag(th_flags[gi])
      );
    end
  endgenerate

  // severe shutdown forces fail-safe directly, not waiting for software
  assign failsafe_req = severe_det || th_flags[STDB_TH_SEVERE];

  // info single-bit flags: clamp, fsi, invalid command, fail outputs
  logic [3:0] di_set;
  logic [3:0] di_flags;
  assign di_set = {reset_stuck_det, failsafe_input_pattern_flag_det, frame_valid && frame_invalid, fail_outputs_on};
  generate
    for (gi = 0; gi < 4; gi++) begin : g_di
      stdb_flag_bit u_bit (
        .clk(sys_clk),
        .rst_n(rst_n),
        .set_evt(di_set[gi]),
        .clr_req(clr_di),
        .flag(di_flags[gi])
      );
    end
  endgenerate

  // previous-state field and watchdog counter
  logic [1:0] prev_reg;
  logic [1:0] prev_next;
  logic [1:0] wdc_reg;
  logic [1:0] wdc_next;
  logic fail_cause;
  // overvoltage counts as a failure only when its reset is enabled
  assign fail_cause = restart_from_fail || (main_high_det && overvoltage_reset_enable);

  // restart records its cause; otherwise only a clear frame moves the field
  always_comb begin
    prev_next = prev_reg;
    if (restart_pulse && fail_cause) begin
      prev_next = STDB_PREV_FAIL;
    end else if (restart_pulse && restart_from_sleep) begin
      prev_next = STDB_PREV_SLEEP;
    end else if (clr_di) begin
      prev_next = STDB_PREV_CLEAR;
    end
  end

  // counter saturates at two; only a good trigger clears it, never software
  always_comb begin
    wdc_next = wdc_reg;
    if (watchdog_fail_evt) begin
      if (wdc_reg == STDB_WDC_NONE) begin
        wdc_next = STDB_WDC_ONE;
      end else begin
        wdc_next = STDB_WDC_TWO;
      end
    end else if (watchdog_good_evt) begin
      wdc_next = STDB_WDC_NONE;
    end
  end

  // register only; restart has no reset effect here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= STDB_PREV_CLEAR;
      wdc_reg <= STDB_WDC_NONE;
    end else begin
      prev_reg <= prev_next;
      wdc_reg <= wdc_next;
    end
  end

  // fail-safe output configuration follows the counter
  assign fail_safe_outputs = wdc_reg;

  // assembled registers, reserved bits read zero
  logic [7:0] th_word;
  logic [7:0] di_word;
  assign th_word = {5'h00, th_flags};
  assign di_word = {prev_reg, di_flags[3], di_flags[2], wdc_reg, di_flags[1], di_flags[0]};

  // read data: snapshot taken before the clear lands, unmapped reads 0x00
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (frame_valid) begin
      rvalid_next = 1'b1;
      unique case (frame_addr)
        STDB_ADDR_SUPPLY: rdata_next = sup_flags;
        STDB_ADDR_THERMAL: rdata_next = th_word;
        STDB_ADDR_DEVINFO: rdata_next = di_word;
        default: rdata_next = STDB_RESET_VAL;
      endcase
    end
  end

  // register only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= STDB_RESET_VAL;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end
  assign read_data = rdata_reg;
  assign read_valid = rvalid_reg;

  // checks
  AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sup_flags[STDB_SUP_RSVD] == 1'b0 && th_word[7:3] == 5'h00) else $error("reserved bit set");
  AST_SHORT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    main_short_det && main_on |=> sup_flags[STDB_SUP_MAIN_SHORT]) else $error("short flag missed");
  AST_MAIN_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !main_on && !clr_sup && !sup_flags[STDB_SUP_MAIN_LOW] |=> !sup_flags[STDB_SUP_MAIN_LOW])
    else $error("low flag set while off");
  AST_SEC_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sec_on && !sup_flags[STDB_SUP_SEC_HOT] |=> !sup_flags[STDB_SUP_SEC_HOT]) else $error("hot flag while off");
  AST_LIN_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !lin_active && !sup_flags[STDB_SUP_LIN_LOW] |=> !sup_flags[STDB_SUP_LIN_LOW]) else $error("lin flag set");
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_th && first_det |=> th_flags[STDB_TH_FIRST]) else $error("event lost on clear");
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_th && th_set == 3'h0 |=> th_flags == 3'h0) else $error("clear failed");
  AST_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clr_sup |=> (sup_flags & ~$past(sup_flags)) == 8'h00 || $past(sup_set) != 8'h00)
    else $error("flag changed alone");
  AST_WDC_SAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wdc_reg != 2'h3) else $error("counter reached three");
  AST_WDC_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_di && !watchdog_good_evt && !watchdog_fail_evt |=> $stable(wdc_reg))
    else $error("counter moved by a clear frame");
  AST_WDC_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    watchdog_fail_evt && wdc_reg == STDB_WDC_NONE |=> wdc_reg == STDB_WDC_ONE ##0 fail_safe_outputs == 2'h1)
    else $error("counter step");
  AST_SPI_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_valid && frame_invalid |=> di_flags[2'h1] && $stable(th_flags[STDB_TH_PREWARN]) || prewarn_det)
    else $error("invalid command");
  AST_SEVERE_FS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    severe_det |-> failsafe_req ##1 th_flags[STDB_TH_SEVERE]) else $error("severe missed");
endmodule : stdb_status_bank

// ==== verification/stdb_mcu_model.sv ====
// controller-side frame master model for the status bank
`timescale 1ns/1ps
module stdb_mcu_model (
  // clock
  input wire logic sys_clk,
  // frame port towards the bank
  output logic frame_valid,
  output logic [15:0] frame_data,
  output logic frame_invalid
);
  // pending frames, bit 16 marks an invalid command
  logic [16:0] frame_q[$];
  // frame being driven
  logic [16:0] cur;
  initial begin
    frame_valid = 1'b0;
    frame_data = 16'h0000;
    frame_invalid = 1'b0;
  end
  // one whole frame per cycle just after the edge, back to back when queued
  always @(posedge sys_clk) begin
    #1;
    if (frame_q.size() > 0) begin
      cur = frame_q.pop_front();
      frame_valid <= 1'b1;
      frame_data <= cur[15:0];
      frame_invalid <= cur[16];
    end else begin
      // idle data toggles so a stale frame can never look valid
      frame_valid <= 1'b0;
      frame_data <= ~frame_data;
      frame_invalid <= 1'b0;
    end
  end
  // queue a frame: address, mode bit 7, ignored data byte
  task automatic send(input logic [6:0] a, input logic c, input logic inv, input logic [7:0] d);
    frame_q.push_back({inv, d, c, a});
  endtask : send
endmodule : stdb_mcu_model

// ==== verification/stdb_tb.sv ====
// self-checking testbench of the status bank
`timescale 1ns/1ps
module testbench
  import stdb_pkg::*;
;
  localparam logic [6:0] A_S = STDB_ADDR_SUPPLY;
  localparam logic [6:0] A_T = STDB_ADDR_THERMAL;
  localparam logic [6:0] A_D = STDB_ADDR_DEVINFO;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  // detector levels, supply bits in place, thermal at 10:8, info at 13:11
  logic [13:0] det = '0;
  // main_on, sec_on, lin_active
  logic [2:0] pwr = 3'h7;
  // restart and watchdog controls
  logic rs_p = 1'b0, rs_f = 1'b0, rs_s = 1'b0, ove = 1'b0, wd_f = 1'b0, wd_g = 1'b0;
  logic frame_valid, frame_invalid, read_valid, failsafe_req;
  logic [15:0] frame_data;
  logic [7:0] read_data;
  logic [1:0] fail_safe_outputs;
  // expected bytes in frame order
  logic [7:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  stdb_mcu_model mcu (.sys_clk(sys_clk), .frame_valid(frame_valid), .frame_data(frame_data),
    .frame_invalid(frame_invalid));
  stdb_status_bank DUT (.sys_clk(sys_clk), .resetn(resetn), .frame_valid(frame_valid),
    .frame_data(frame_data), .frame_invalid(frame_invalid), .read_data(read_data),
    .read_valid(read_valid), .por_event(det[7]), .lin_low_det(det[6]), .main_high_det(det[5]),
    .sec_hot_det(det[4]), .sec_low_det(det[3]), .main_short_det(det[2]), .main_low_det(det[0]),
    .main_on(pwr[2]), .sec_on(pwr[1]), .lin_active(pwr[0]), .severe_det(det[10]),
    .first_det(det[9]), .prewarn_det(det[8]), .restart_pulse(rs_p), .restart_from_fail(rs_f),
    .restart_from_sleep(rs_s), .overvoltage_reset_enable(ove), .watchdog_fail_evt(wd_f),
    .watchdog_good_evt(wd_g), .reset_stuck_det(det[13]), .failsafe_input_pattern_flag_det(det[12]),
    .fail_outputs_on(det[11]), .failsafe_req(failsafe_req), .fail_safe_outputs(fail_safe_outputs));
  // verdict and end of run, reached from every path
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // count a mismatch
  task automatic bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  // compare one returned byte
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) bad($sformatf("byte %h exp %h", g, e));
  endtask : chk8
  // compare a side output
  task automatic chk_o(input logic [1:0] g, input logic [1:0] e);
    cmp_count++;
    if (g !== e) bad($sformatf("output %h exp %h", g, e));
  endtask : chk_o
  // step to just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // one-cycle detector burst, flags visible afterwards
  task automatic pulse(input logic [13:0] d);
    det = d;
    tick(1);
    det = '0;
    tick(1);
  endtask : pulse
  // queue a read or clear with its expected byte, random ignored data byte
  task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e, input logic inv = 1'b0);
    exp_q.push_back(e);
    mcu.send(a, c, inv, 8'($urandom));
  endtask : rd
  // wait, bounded, until every queued byte came back
  task automatic flush;
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 20) begin
      tick(1);
      n++;
    end
    if (exp_q.size() > 0) begin
      bad("no answer");
      end_sim;
    end else begin
      tick(1);
    end
  endtask : flush
  // watcher: a returned byte stands one cycle, looked at mid-cycle
  always @(negedge sys_clk) begin
    if (read_valid === 1'b1) begin
      if (exp_q.size() == 0) bad("unexpected byte");
      else chk8(read_data, exp_q.pop_front());
    end
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad("timeout");
    end_sim;
  end
  initial begin
    void'($urandom(32'hD50F));
    tick(16);
    resetn = 1'b1;
    tick(4);
    rd(A_S, 0, 8'h00);
    rd(A_T, 0, 8'h00);
    rd(A_D, 0, 8'h00);
    rd(7'h44, 1, 8'h00);
    flush;
    pulse(14'h0080);
    rd(A_S, 1, 8'h80);
    rd(A_S, 0, 8'h00);
    flush;
    pulse(14'h00FF);
    rd(A_S, 0, 8'hFD);
    rd(A_S, 1, 8'hFD);
    flush;
    // regulators and transceivers off gate their flags, main high still sets
    pwr = 3'h0;
    pulse(14'h00FF);
    pwr = 3'h7;
    rd(A_S, 1, 8'hA0);
    flush;
    det = 14'h0400;
    #1 chk_o({1'b0, failsafe_req}, 2'h1);
    tick(1);
    det = '0;
    pulse(14'h0300);
    chk_o({1'b0, failsafe_req}, 2'h1);
    // restart from sleep keeps thermal flags
    rs_p = 1;
    rs_s = 1;
    tick(1);
    rs_p = 0;
    rs_s = 0;
    tick(1);
    rd(A_T, 0, 8'h07);
    rd(A_T, 1, 8'h07);
    rd(A_T, 0, 8'h00);
    rd(A_D, 1, 8'h80);
    flush;
    chk_o({1'b0, failsafe_req}, 2'h0);
    pulse(14'h3800);
    pulse(14'h0000);
    wd_f = 1;
    tick(1);
    wd_f = 0;
    tick(1);
    chk_o(fail_safe_outputs, 2'h1);
    rd(A_D, 0, 8'h35);
    flush;
    repeat (2) begin
      wd_f = 1;
      tick(1);
      wd_f = 0;
      tick(1);
    end
    chk_o(fail_safe_outputs, 2'h2);
    rd(A_D, 1, 8'h39, 1'b1);
    flush;
    tick(20);
    rd(A_D, 0, 8'h3B);
    rd(A_D, 1, 8'h3B);
    rd(A_D, 0, 8'h08);
    flush;
    wd_g = 1;
    tick(1);
    wd_g = 0;
    tick(1);
    chk_o(fail_safe_outputs, 2'h0);
    // failure causes versus wake from sleep, overvoltage only when enabled
    for (int k = 0; k < 3; k++) begin
      rs_f = (k == 0);
      ove = (k == 1);
      rs_s = (k == 2);
      det[5] = (k != 0);
      rs_p = 1;
      tick(1);
      {rs_p, rs_f, rs_s, ove} = 4'h0;
      det = '0;
      tick(1);
      rd(A_D, 1, (k == 2) ? 8'h80 : 8'h40);
      flush;
    end
    // an event during the clear cycle survives it
    det = 14'h0100;
    tick(2);
    rd(A_T, 1, 8'h01);
    flush;
    det = '0;
    tick(1);
    rd(A_T, 1, 8'h01);
    rd(A_T, 0, 8'h00);
    flush;
    // second reset in mid-run
    pulse(14'h3880);
    resetn = 1'b0;
    tick(3);
    resetn = 1'b1;
    tick(4);
    rd(A_D, 0, 8'h00);
    rd(A_S, 0, 8'h00);
    flush;
    end_sim;
  end
endmodule : testbench
